// File: core/dsa_alarm.v
// dual setpoint alarm: apb registers, push-button menu, two channels
`timescale 1ns/1ps
`include "dsa_map.vh"
module dsa_alarm #(
    parameter SEC_CYC = `DSA_SEC_CYC,
    parameter ALT_CYC = `DSA_ALT_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] display_bcd,
    input wire btn_sel,
    input wire btn_up,
    input wire btn_down,
    input wire btn_exit,
    output wire [1:0] alarm_switch_closed,
    output reg disp_show_alarm,
    output reg [1:0] disp_alarm_id,
    output reg [2:0] menu_state,
    output reg [2:0] menu_pos,
    output reg [2:0] menu_item,
    output reg [15:0] edit_value,
    output reg [1:0] edit_digit,
    output reg irq
);
    localparam [24:0] ALT_M1 = ALT_CYC[24:0] - 25'h0000001;

    function [13:0] bcd2bin;
        input [15:0] b;
        begin
            bcd2bin = b[15:12] * 14'd1000 + b[11:8] * 14'd100 + b[7:4] * 14'd10 + b[3:0];
        end
    endfunction

    reg [8:0] ctrl;
    reg [15:0] num [0:`DSA_NUM_COUNT-1];
    reg [1:0] status;
    reg [1:0] mask;
    reg [3:0] btn_prev;
    reg accept;
    reg [24:0] alt_cnt;
    reg alt_phase;
    integer i;

    wire [1:0] cond;
    wire [1:0] active;
    wire [1:0] silenced;
    wire [1:0] evt;

    // one generate body per channel keeps both channels identical
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ch
            dsa_chan #(.SEC_CYC(SEC_CYC)) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .en(ctrl[g*`DSA_CB_STRIDE+`DSA_CB_EN]),
                .high(ctrl[g*`DSA_CB_STRIDE+`DSA_CB_HL]),
                .sense(ctrl[g*`DSA_CB_STRIDE+`DSA_CB_SENSE]),
                .disp(bcd2bin(display_bcd)),
                .sp(bcd2bin(num[g*`DSA_NUM_STRIDE+`DSA_NUM_SP])),
                .hyst(bcd2bin(num[g*`DSA_NUM_STRIDE+`DSA_NUM_HYST])),
                .delay(bcd2bin(num[g*`DSA_NUM_STRIDE+`DSA_NUM_DELAY])),
                .silence_time(bcd2bin(num[g*`DSA_NUM_STRIDE+`DSA_NUM_SIL])),
                .accept(accept),
                .cond(cond[g]),
                .active(active[g]),
                .silenced(silenced[g]),
                .switch_closed(alarm_switch_closed[g]),
                .event_pulse(evt[g])
            );
        end
    endgenerate

    // button edges; chords are checked before single presses
    wire [3:0] btn = {btn_exit, btn_down, btn_up, btn_sel};
    wire [3:0] press = btn & ~btn_prev;
    wire any_press = |press;
    wire chord_prog = btn_sel & btn_exit & any_press;
    wire chord_dir = btn_sel & btn_up & any_press;
    wire p_sel = press[0] & ~chord_prog & ~chord_dir;
    wire p_up = press[1] & ~chord_dir;
    wire p_down = press[2];
    wire p_exit = press[3] & ~chord_prog;

    // field selected by menu position and item
    reg is_opt;
    reg [3:0] fld;
    reg [3:0] bit_i;
    reg [2:0] n_items;
    always @* begin
        is_opt = 1'b0;
        fld = 4'h0;
        bit_i = 4'h0;
        n_items = `DSA_AL_ITEMS;
        case (menu_pos)
            `DSA_POS_AL1, `DSA_POS_AL2: begin
                case (menu_item)
                    3'h0: begin is_opt = 1'b1; bit_i = `DSA_CB_EN; end
                    3'h1: fld = `DSA_NUM_SP;
                    3'h2: begin is_opt = 1'b1; bit_i = `DSA_CB_HL; end
                    3'h3: begin is_opt = 1'b1; bit_i = `DSA_CB_SENSE; end
                    3'h4: fld = `DSA_NUM_HYST;
                    3'h5: fld = `DSA_NUM_DELAY;
                    default: fld = `DSA_NUM_SIL;
                endcase
                if (menu_pos == `DSA_POS_AL2) begin
                    fld = fld + `DSA_NUM_STRIDE;
                    bit_i = bit_i + `DSA_CB_STRIDE;
                end
            end
            `DSA_POS_ACC: begin
                n_items = `DSA_ACC_ITEMS;
                is_opt = (menu_item == 3'h0);
                bit_i = `DSA_CB_ACC;
                fld = `DSA_NUM_CODE;
            end
            `DSA_POS_DIR: begin
                n_items = `DSA_ACC_ITEMS;
                fld = (menu_item == 3'h0) ? `DSA_NUM_SP : `DSA_NUM_STRIDE + `DSA_NUM_SP;
            end
            default: fld = `DSA_NUM_CODE;
        endcase
    end

    wire [3:0] cur_nib = edit_value[edit_digit*4 +: 4];
    wire [3:0] nib_up = (cur_nib >= 4'h9) ? 4'h0 : cur_nib + 4'h1;
    wire [3:0] nib_dn = (cur_nib == 4'h0) ? 4'h9 : cur_nib - 4'h1;
    wire [2:0] item_last = n_items - 3'h1;
    wire code_open = (num[`DSA_NUM_CODE] == `DSA_NUM_RST);
    reg menu_wr_num;
    reg menu_wr_opt;

    // button menu
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_prev <= 4'h0;
            accept <= 1'b0;
            menu_state <= `DSA_ST_DISP;
            menu_pos <= `DSA_POS_COND;
            menu_item <= 3'h0;
            edit_value <= 16'h0000;
            edit_digit <= 2'h3;
            menu_wr_num <= 1'b0;
            menu_wr_opt <= 1'b0;
        end else if (ce) begin
            btn_prev <= btn;
            accept <= 1'b0;
            menu_wr_num <= 1'b0;
            menu_wr_opt <= 1'b0;
            case (menu_state)
                `DSA_ST_DISP: begin
                    if (chord_prog) begin
                        menu_state <= `DSA_ST_PROMPT;
                        menu_pos <= `DSA_POS_COND;
                    end else if (chord_dir && ctrl[`DSA_CB_ACC]) begin
                        // code 0000 opens the setpoints without asking
                        menu_item <= 3'h0;
                        edit_value <= 16'h0000;
                        edit_digit <= 2'h3;
                        menu_pos <= code_open ? `DSA_POS_DIR : `DSA_POS_KEY;
                        menu_state <= code_open ? `DSA_ST_SUB : `DSA_ST_NUM;
                    end else if (p_sel) begin
                        accept <= 1'b1;
                    end
                end
                `DSA_ST_PROMPT: begin
                    // alarm entries sit between cond and code
                    if (p_up) begin
                        menu_pos <= (menu_pos == `DSA_POS_CODE) ? `DSA_POS_COND
                                                                : menu_pos + 3'h1;
                    end else if (p_down) begin
                        menu_pos <= (menu_pos == `DSA_POS_COND) ? `DSA_POS_CODE
                                                                : menu_pos - 3'h1;
                    end else if (p_sel && menu_pos != `DSA_POS_COND
                                 && menu_pos != `DSA_POS_CODE) begin
                        menu_state <= `DSA_ST_SUB;
                        menu_item <= 3'h0;
                    end else if (p_exit) begin
                        menu_state <= `DSA_ST_DISP;
                    end
                end
                `DSA_ST_SUB: begin
                    if (p_up) begin
                        menu_item <= (menu_item >= item_last) ? 3'h0 : menu_item + 3'h1;
                    end else if (p_down) begin
                        menu_item <= (menu_item == 3'h0) ? item_last : menu_item - 3'h1;
                    end else if (p_sel) begin
                        // select reveals the stored value
                        edit_value <= is_opt ? {15'h0000, ctrl[bit_i]} : num[fld];
                        edit_digit <= 2'h3;
                        menu_state <= is_opt ? `DSA_ST_OPT : `DSA_ST_NUM;
                    end else if (p_exit) begin
                        menu_state <= (menu_pos == `DSA_POS_DIR) ? `DSA_ST_DISP
                                                                 : `DSA_ST_PROMPT;
                    end
                end
                `DSA_ST_OPT: begin
                    if (p_up || p_down) begin
                        edit_value <= {15'h0000, ~edit_value[0]};
                    end else if (p_exit) begin
                        menu_wr_opt <= 1'b1;
                        menu_state <= `DSA_ST_SUB;
                    end
                end
                `DSA_ST_NUM: begin
                    if (p_up) begin
                        edit_value[edit_digit*4 +: 4] <= nib_up;
                    end else if (p_down) begin
                        edit_value[edit_digit*4 +: 4] <= nib_dn;
                    end else if (p_sel) begin
                        edit_digit <= edit_digit - 2'h1;
                    end else if (p_exit) begin
                        if (menu_pos == `DSA_POS_KEY) begin
                            // wrong code drops back to the display
                            menu_state <= (edit_value == num[`DSA_NUM_CODE]) ? `DSA_ST_SUB
                                                                            : `DSA_ST_DISP;
                            menu_pos <= `DSA_POS_DIR;
                            menu_item <= 3'h0;
                        end else begin
                            menu_wr_num <= 1'b1;
                            menu_state <= `DSA_ST_SUB;
                        end
                    end
                end
                default: menu_state <= `DSA_ST_DISP;
            endcase
        end
    end

    // write-back latches the target one cycle late; fld and bit_i hold meanwhile
    wire apb_wr = psel & penable & pready & pwrite;
    wire num_hit = (paddr >= `DSA_OFF_NUM_FIRST) && (paddr <= `DSA_OFF_NUM_LAST)
                   && (paddr[1:0] == 2'h0);
    wire [7:0] num_off = paddr - `DSA_OFF_NUM_FIRST;
    wire [3:0] num_idx = num_off[5:2];
    wire [1:0] next_status = (status & ~((apb_wr && paddr == `DSA_OFF_STATUS) ? pwdata[1:0]
                                                                              : 2'h0)) | evt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `DSA_CTRL_RST;
            for (i = 0; i < `DSA_NUM_COUNT; i = i + 1) begin
                num[i] <= `DSA_NUM_RST;
            end
            status <= 2'h0;
            mask <= 2'h0;
            irq <= 1'b0;
        end else if (ce) begin
            if (menu_wr_opt) begin
                ctrl[bit_i] <= edit_value[0];
            end
            if (menu_wr_num) begin
                num[fld] <= edit_value;
            end
            // bus write lands after the menu, so it wins a same-cycle clash
            if (apb_wr && paddr == `DSA_OFF_CTRL) begin
                ctrl <= pwdata[8:0];
            end
            if (apb_wr && num_hit) begin
                num[num_idx] <= pwdata[15:0];
            end
            if (apb_wr && paddr == `DSA_OFF_MASK) begin
                mask <= pwdata[1:0];
            end
            status <= next_status; // event set beats the clear
            irq <= |(next_status & mask);
        end
    end

    // apb slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h00000000;
                if (num_hit) begin
                    prdata <= {16'h0000, num[num_idx]};
                end else begin
                    case (paddr)
                        `DSA_OFF_CTRL: prdata <= {23'h000000, ctrl};
                        `DSA_OFF_STATUS: prdata <= {30'h00000000, status};
                        `DSA_OFF_MASK: prdata <= {30'h00000000, mask};
                        `DSA_OFF_STATE: prdata <= {26'h0000000, silenced, active, cond};
                        default: pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end

    // alternating display; a disabled channel is never active
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_cnt <= 25'h0000000;
            alt_phase <= 1'b0;
            disp_show_alarm <= 1'b0;
            disp_alarm_id <= 2'h0;
        end else if (ce) begin
            if (active == 2'h0) begin
                alt_cnt <= 25'h0000000;
                alt_phase <= 1'b0;
            end else if (alt_cnt == ALT_M1) begin
                alt_cnt <= 25'h0000000;
                alt_phase <= ~alt_phase;
            end else begin
                alt_cnt <= alt_cnt + 25'h0000001;
            end
            disp_show_alarm <= alt_phase & (active != 2'h0);
            disp_alarm_id <= active;
        end
    end
endmodule // dsa_alarm

// File: core/dsa_chan.v
// one setpoint alarm channel: hysteresis compare, delay and silence timing
`timescale 1ns/1ps
`include "dsa_map.vh"
module dsa_chan #(
    parameter SEC_CYC = `DSA_SEC_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire en,
    input wire high,
    input wire sense,
    input wire [13:0] disp,
    input wire [13:0] sp,
    input wire [13:0] hyst,
    input wire [13:0] delay,
    input wire [13:0] silence_time,
    input wire accept,
    output reg cond,
    output reg active,
    output reg silenced,
    output reg switch_closed,
    output reg event_pulse
);
    localparam [25:0] SEC_M1 = SEC_CYC[25:0] - 26'h0000001;
    reg [25:0] pres;
    reg [13:0] secs;
    wire [14:0] d_plus_h = {1'b0, disp} + {1'b0, hyst};
    wire [14:0] s_plus_h = {1'b0, sp} + {1'b0, hyst};
    wire set_c = high ? (disp >= sp) : (disp <= sp);
    wire clr_c = high ? (d_plus_h < {1'b0, sp}) : ({1'b0, disp} > s_plus_h);
    wire sec_tick = (pres == SEC_M1);
    wire [25:0] next_pres = sec_tick ? 26'h0000000 : pres + 26'h0000001;
    wire [13:0] next_secs = sec_tick ? secs + 14'h0001 : secs;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond <= 1'b0;
            active <= 1'b0;
            silenced <= 1'b0;
            switch_closed <= 1'b1;
            event_pulse <= 1'b0;
            pres <= 26'h0000000;
            secs <= 14'h0000;
        end else if (ce) begin
            event_pulse <= 1'b0;
            // sense only flips the polarity of the switch
            switch_closed <= ~(sense ^ (active & ~silenced));
            if (!en) begin
                // parameters live in the parent, so nothing is lost here
                cond <= 1'b0;
                active <= 1'b0;
                silenced <= 1'b0;
                pres <= 26'h0000000;
                secs <= 14'h0000;
            end else if (!cond) begin
                cond <= set_c;
                pres <= 26'h0000000;
                secs <= 14'h0000;
            end else if (clr_c) begin
                cond <= 1'b0;
                active <= 1'b0;
                silenced <= 1'b0;
                pres <= 26'h0000000;
                secs <= 14'h0000;
            end else if (!active) begin
                // delay counts from the compare, zero means at once
                if (secs >= delay) begin
                    active <= 1'b1;
                    event_pulse <= 1'b1;
                    pres <= 26'h0000000;
                    secs <= 14'h0000;
                end else begin
                    pres <= next_pres;
                    secs <= next_secs;
                end
            end else if (silenced) begin
                if (secs >= silence_time) begin
                    silenced <= 1'b0;
                    pres <= 26'h0000000;
                    secs <= 14'h0000;
                end else begin
                    pres <= next_pres;
                    secs <= next_secs;
                end
            end else if (accept && silence_time != 14'h0000) begin
                // output drops, indication stays via active
                silenced <= 1'b1;
                pres <= 26'h0000000;
                secs <= 14'h0000;
            end
        end
    end
endmodule // dsa_chan

// File: core/dsa_map.vh
// register map, field positions, reset values and timing counts
`ifndef DSA_MAP_VH
`define DSA_MAP_VH
`define DSA_CLK_NS 20
`define DSA_SEC_NS 1000000000
`define DSA_SEC_CYC (`DSA_SEC_NS / `DSA_CLK_NS)
`define DSA_ALT_NS 500000000
`define DSA_ALT_CYC (`DSA_ALT_NS / `DSA_CLK_NS)
`define DSA_OFF_CTRL 8'h00
`define DSA_OFF_NUM_FIRST 8'h04
`define DSA_OFF_NUM_LAST 8'h24
`define DSA_OFF_STATUS 8'h28
`define DSA_OFF_MASK 8'h2c
`define DSA_OFF_STATE 8'h30
`define DSA_NUM_COUNT 9
`define DSA_NUM_STRIDE 4'h4
`define DSA_NUM_SP 4'h0
`define DSA_NUM_HYST 4'h1
`define DSA_NUM_DELAY 4'h2
`define DSA_NUM_SIL 4'h3
`define DSA_NUM_CODE 4'h8
`define DSA_CB_EN 4'h0
`define DSA_CB_HL 4'h1
`define DSA_CB_SENSE 4'h2
`define DSA_CB_STRIDE 4'h4
`define DSA_CB_ACC 4'h8
`define DSA_CTRL_RST 9'h000
`define DSA_NUM_RST 16'h0000
`define DSA_ST_DISP 3'h0
`define DSA_ST_PROMPT 3'h1
`define DSA_ST_SUB 3'h2
`define DSA_ST_OPT 3'h3
`define DSA_ST_NUM 3'h4
`define DSA_POS_COND 3'h0
`define DSA_POS_AL1 3'h1
`define DSA_POS_AL2 3'h2
`define DSA_POS_ACC 3'h3
`define DSA_POS_CODE 3'h4
`define DSA_POS_DIR 3'h5
`define DSA_POS_KEY 3'h6
`define DSA_AL_ITEMS 3'h7
`define DSA_ACC_ITEMS 3'h2
`endif

// File: verif/dsa_alarm_props.sv
// port assertions for the dual setpoint alarm
`timescale 1ns/1ps
`include "dsa_map.vh"
module dsa_alarm_chk #(
    parameter ALT_CYC = 4
) (
    input wire pclk,
    input wire presetn,
    input wire btn_sel,
    input wire btn_up,
    input wire btn_exit,
    input wire disp_show_alarm,
    input wire [1:0] disp_alarm_id,
    input wire [2:0] menu_state,
    input wire [2:0] menu_pos,
    input wire [2:0] menu_item,
    input wire [15:0] edit_value,
    input wire [1:0] edit_digit
);
    // chords excluded: they open menus, they do not edit
    wire up1 = btn_up && !btn_sel && !btn_exit;
    wire ex1 = btn_exit && !btn_sel;
    wire in_num = menu_state == `DSA_ST_NUM;
    wire in_opt = menu_state == `DSA_ST_OPT;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_show; $rose(disp_alarm_id != 2'b00) |-> ##[1:10] disp_show_alarm; endproperty
    a_show: assert property (p_show) else $error("alarm id not shown");
    property p_quiet; (disp_alarm_id == 2'b00)[*2] |-> !disp_show_alarm; endproperty
    a_quiet: assert property (p_quiet) else $error("id shown idle");
    property p_next; $rose(btn_sel) && !btn_up && !btn_exit && in_num && edit_digit != 2'd0
        |=> edit_digit == $past(edit_digit) - 2'd1; endproperty
    a_next: assert property (p_next) else $error("digit not advanced");
    property p_digit; $rose(btn_up) && up1 && in_num |=> edit_value != $past(edit_value); endproperty
    a_digit: assert property (p_digit) else $error("digit not changed");
    property p_toggle; $rose(btn_up) && up1 && in_opt
        |=> edit_value[0] != $past(edit_value[0]); endproperty
    a_toggle: assert property (p_toggle) else $error("option not toggled");
    property p_opt_back; $rose(btn_exit) && ex1 && in_opt
        |=> menu_state == `DSA_ST_SUB && $stable(menu_item); endproperty
    a_opt_back: assert property (p_opt_back) else $error("option exit wrong");
    property p_num_back; $rose(btn_exit) && ex1 && in_num && menu_pos != `DSA_POS_KEY
        |=> menu_state == `DSA_ST_SUB; endproperty
    a_num_back: assert property (p_num_back) else $error("number exit wrong");
    property p_menu; menu_state == `DSA_ST_PROMPT |-> menu_pos <= `DSA_POS_CODE; endproperty
    a_menu: assert property (p_menu) else $error("prompt out of list");
endmodule // dsa_alarm_chk

// File: verif/dsa_annunc.sv
// annunciator wired across the two alarm contacts
`timescale 1ns/1ps
module dsa_annunc (
    input wire pclk,
    input wire presetn,
    input wire [1:0] contact_closed,
    input wire [1:0] sense_closed,
    output reg [1:0] sounding
);
    // sounds while a contact sits in its alarm state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) sounding <= 2'b00;
        else sounding <= contact_closed ~^ sense_closed;
    end
endmodule // dsa_annunc

// File: verif/tb_top.sv
// self-checking bench for the dual setpoint alarm
`timescale 1ns/1ps
`include "dsa_map.vh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic btn_sel = 1'b0, btn_up = 1'b0, btn_down = 1'b0, btn_exit = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'h6c11;
    logic [15:0] disp = 16'h0;
    logic [1:0] sense = 2'b00;
    int failures = 0, samples_checked = 0;
    wire [31:0] prdata;
    wire pready, pslverr, disp_show_alarm, irq;
    wire [1:0] sw, disp_alarm_id, edit_digit, snd;
    wire [2:0] menu_state, menu_pos, menu_item;
    wire [15:0] edit_value;
    always #10 pclk = ~pclk;
    // a second shrinks to ten cycles so delays stay short
    dsa_alarm #(.SEC_CYC(10), .ALT_CYC(4)) i_dut (.display_bcd(disp),
        .alarm_switch_closed(sw), .*);
    dsa_annunc i_horn (.pclk(pclk), .presetn(presetn), .contact_closed(sw),
        .sense_closed(sense), .sounding(snd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            failures++;
            tally_and_finish();
        end
    endtask
    // buttons as {select, up, down, exit}, held long enough to be seen
    task automatic press(input logic [3:0] b);
        @(posedge pclk);
        {btn_sel, btn_up, btn_down, btn_exit} <= b;
        repeat (3) @(posedge pclk);
        {btn_sel, btn_up, btn_down, btn_exit} <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h0, rd);
        apb(1'b0, 8'h34, 32'h0);
        check("unmapped", 32'h1, 32'(err));
        for (int k = 0; k < 4; k++) begin
            int ch, hi, h, s, sp, act;
            int off[4];
            ch = k % 2;
            hi = k / 2;
            h = rnd() % 10;
            s = rnd() % 2;
            sp = 240 + 1000 * ch;
            off = '{1, 0, h, h + 1};
            disp <= bcd(hi ? sp - 1 : sp + 1);
            sense[ch] <= s[0];
            apb(1'b1, 8'(4 + 16 * ch), 32'(bcd(sp)));
            apb(1'b1, 8'(8 + 16 * ch), 32'(bcd(h)));
            apb(1'b1, 8'(12 + 16 * ch), 32'h0);
            apb(1'b1, 8'(16 + 16 * ch), 32'h0);
            apb(1'b1, 8'h00, 32'(1 + 2 * hi + 4 * s) << (4 * ch));
            for (int j = 0; j < 4; j++) begin
                act = (j == 1 || j == 2);
                @(posedge pclk);
                disp <= bcd(hi ? sp - off[j] : sp + off[j]);
                repeat (6) @(posedge pclk);
                check("contact", 32'(act == s), 32'(sw[ch]));
                check("idle contact", 32'h1, 32'(sw[1 - ch]));
                check("alarm id", 32'(act << ch), 32'(disp_alarm_id));
                check("sounder", 32'(act), 32'(snd[ch]));
            end
        end
        disp <= bcd(100);
        sense <= 2'b00;
        apb(1'b1, 8'h04, 32'h0240);
        apb(1'b1, 8'h0c, 32'h0002);
        apb(1'b1, 8'h10, 32'h0001);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h28, 32'h3);
        apb(1'b1, 8'h2c, 32'h0);
        @(posedge pclk);
        disp <= bcd(240);
        repeat (15) @(posedge pclk);
        check("early contact", 32'h1, 32'(sw[0]));
        repeat (15) @(posedge pclk);
        check("late contact", 32'h0, 32'(sw[0]));
        check("masked irq", 32'h0, 32'(irq));
        apb(1'b1, 8'h2c, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq", 32'h1, 32'(irq));
        apb(1'b1, 8'h28, 32'h1);
        repeat (2) @(posedge pclk);
        check("cleared irq", 32'h0, 32'(irq));
        press(4'h8);
        check("silenced", 32'h1, 32'(sw[0]));
        check("silenced id", 32'h1, 32'(disp_alarm_id));
        repeat (15) @(posedge pclk);
        check("resumed", 32'h0, 32'(sw[0]));
        apb(1'b1, 8'h00, 32'h0);
        repeat (4) @(posedge pclk);
        check("disabled", 32'h1, 32'(sw[0]));
        apb(1'b0, 8'h04, 32'h0);
        check("kept sp one", 32'h0240, rd);
        apb(1'b0, 8'h14, 32'h0);
        check("kept sp two", 32'h1240, rd);
        apb(1'b1, 8'h00, 32'h100);
        press(4'hc);
        check("direct list", 32'(`DSA_POS_DIR), 32'(menu_pos));
        press(4'h1);
        // a set code forces the key entry; a wrong key drops to the display
        apb(1'b1, 8'h24, 32'h9000);
        press(4'hc);
        check("key entry", 32'(`DSA_POS_KEY), 32'(menu_pos));
        press(4'h1);
        check("wrong key", 32'(`DSA_ST_DISP), 32'(menu_state));
        press(4'hc);
        press(4'h2);
        press(4'h1);
        check("right key", 32'(`DSA_ST_SUB), 32'(menu_state));
        check("right key list", 32'(`DSA_POS_DIR), 32'(menu_pos));
        press(4'h1);
        press(4'h9);
        check("prompt", 32'(`DSA_ST_PROMPT), 32'(menu_state));
        for (int n = 0; n < 6 && menu_pos !== `DSA_POS_AL1; n++) press(4'h4);
        press(4'h8);
        for (int i = 0; i < 7; i++) begin
            press(4'h8);
            press(4'h4);
            if (menu_state === `DSA_ST_NUM) press(4'h8);
            press(4'h1);
            check("item", 32'(`DSA_ST_SUB), 32'(menu_state));
            press(4'h4);
        end
        apb(1'b0, 8'h04, 32'h0);
        check("menu sp one", 32'h1240, rd);
        apb(1'b0, 8'h00, 32'h0);
        check("menu options", 32'h107, rd);
        tally_and_finish();
    end
endmodule // tb_top
bind dsa_alarm dsa_alarm_chk #(.ALT_CYC(ALT_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
    .btn_sel(btn_sel), .btn_up(btn_up), .btn_exit(btn_exit),
    .disp_show_alarm(disp_show_alarm), .disp_alarm_id(disp_alarm_id),
    .menu_state(menu_state), .menu_pos(menu_pos), .menu_item(menu_item),
    .edit_value(edit_value), .edit_digit(edit_digit));
